// >>> logic/eda_eeprom_ctrl.sv
// data eeprom access control: special registers, unlock check, write timer
// assumes core and warm reset on ref_clk; protect strap comes from a pin
//
// Contract
// - read strobe loads data register next cycle
// - data register holds until read or write
// - keys 55h then AAh then write strobe
// - wrong cycle count suppresses the write
// - write strobe ignored while gate clear
// - hardware never clears the write gate
// - started write completes despite gate clear
// - write end clears strobe, sets done flag
// - done flag cleared only by software
// - power-up clears the write gate
// - power-up timer blocks write start
// - protected data stays core accessible
// - strobes set only by software, hardware clears
// - warm reset mid-write sets error, clears regs
// - unlock port reads as zero
`timescale 1ns/1ps
module eda_eeprom_ctrl
    import eda_pkg::*;
#(
    parameter int DEPTH     = 256,
    parameter int PWRT_CYC  = EDA_PWRT_CYC,
    parameter int WRITE_CYC = EDA_WRITE_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         warm_rst,
    input  wire eda_sfr_req_t sfr_req,
    input  wire logic         data_protect_config,
    output logic [7:0]        sfr_rdata_ff,
    output logic              irq_req_ff,
    output logic              write_busy_ff,
    output logic              programmer_blind_ff
);
    localparam int AW   = $clog2(DEPTH);
    localparam int HALF = (WRITE_CYC > 3) ? WRITE_CYC / 2 : 2;
    localparam logic [31:0] PHASE_LAST = 32'(HALF - 1);
    localparam logic [31:0] PWRT_LAST  = 32'(PWRT_CYC - 1);

    logic [7:0]  mem [DEPTH];      // eeprom array, no reset
    logic [7:0]  data_ff;          // eeprom_data_byte
    logic [7:0]  loc_ff;           // eeprom_location
    logic        rd_ff;            // read strobe
    logic        wr_ff;            // write strobe, mirrors busy
    logic        gate_ff;          // write_enable_gate
    logic        err_ff;           // write_error_flag
    logic        done_ff;          // write_done_flag
    logic        done_ie_ff;       // write_done_irq_enable
    logic        gie_ff;           // global_irq_enable
    logic        peripheral_irq_enable_ff;          // peripheral_irq_enable
    logic [1:0]  step_ff;          // unlock progress: 0 none, 1 key1, 2 key2
    logic [3:0]  gap_ff;           // cycles since last key
    logic [31:0] wcnt_ff;          // write phase counter
    logic [31:0] pwrt_ff;          // power-up timer
    logic        pwrt_done_ff;     // power-up timer expired
    logic        cpd_s1_ff;        // strap sync stage one
    logic        cpd_s2_ff;        // strap sync stage two
    eda_state_t  state_ff;
    eda_state_t  nxt_state;

    // access decode
    wire ctrl_we   = sfr_req.we && (sfr_req.sel == EDA_SEL_CTRL);
    wire data_we   = sfr_req.we && (sfr_req.sel == EDA_SEL_DATA);
    wire loc_we    = sfr_req.we && (sfr_req.sel == EDA_SEL_LOC);
    wire flags_we  = sfr_req.we && (sfr_req.sel == EDA_SEL_FLAGS);
    wire enab_we   = sfr_req.we && (sfr_req.sel == EDA_SEL_ENAB);
    wire gic_we    = sfr_req.we && (sfr_req.sel == EDA_SEL_GIC);
    wire unlock_we = sfr_req.we && (sfr_req.sel == EDA_SEL_UNLOCK);
    wire key1_hit  = unlock_we && (sfr_req.wdata == EDA_KEY1);
    wire key2_hit  = unlock_we && (sfr_req.wdata == EDA_KEY2);
    wire [AW-1:0] mem_addr = loc_ff[AW-1:0];
    wire [7:0]    rd_byte  = mem[mem_addr];
    // protect strap has no bearing on core access paths
    wire core_ok = 1'b1;
    // exact spacing after second key, checked at the strobe
    wire armed = (step_ff == 2'd2) && (gap_ff == EDA_GAP_CHK);
    wire rd_set = ctrl_we && sfr_req.wdata[EDA_B_RD] && !wr_ff && core_ok;
    // start needs gate, unlock, timer expired and an idle sequencer
    wire wr_go  = ctrl_we && sfr_req.wdata[EDA_B_WR] && gate_ff && armed
                  && pwrt_done_ff && (state_ff == EDA_IDLE) && !warm_rst && core_ok;
    wire phase_end = (wcnt_ff == PHASE_LAST);
    wire prog_end  = (state_ff == EDA_PROG) && phase_end && !warm_rst;
    wire [7:0] ctrl_view = {4'h0, err_ff, gate_ff, wr_ff, rd_ff};
    wire [7:0] rd_mux =
        (sfr_req.sel == EDA_SEL_CTRL)  ? ctrl_view :
        (sfr_req.sel == EDA_SEL_DATA)  ? data_ff :
        (sfr_req.sel == EDA_SEL_LOC)   ? loc_ff :
        (sfr_req.sel == EDA_SEL_FLAGS) ? {done_ff, 7'h00} :
        (sfr_req.sel == EDA_SEL_ENAB)  ? {done_ie_ff, 7'h00} :
        (sfr_req.sel == EDA_SEL_GIC)   ? {gie_ff, peripheral_irq_enable_ff, 6'h00} :
        EDA_ZERO; // unlock port and unused codes read zero

    // write sequencer next state; warm reset aborts
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            EDA_IDLE:  if (wr_go) nxt_state = EDA_ERASE;
            EDA_ERASE: if (phase_end) nxt_state = EDA_PROG;
            EDA_PROG:  if (phase_end) nxt_state = EDA_IDLE;
            default:   nxt_state = EDA_IDLE;
        endcase
        if (warm_rst) begin
            nxt_state = EDA_IDLE;
        end
    end

    // sequencer and phase counter
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= EDA_IDLE;
            wcnt_ff  <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            // counter restarts on every state change
            wcnt_ff  <= (nxt_state != state_ff) ? 32'h0 : wcnt_ff + 32'h1;
        end
    end

    // array: erase to ones, then program the data byte
    always_ff @(posedge ref_clk) begin
        if (!srst && !warm_rst && phase_end && (state_ff == EDA_ERASE)) begin
            mem[mem_addr] <= EDA_ERASED;
        end else if (!srst && prog_end) begin
            mem[mem_addr] <= data_ff;
        end
    end

    // unlock tracker; any stray unlock write or late key drops it
    always_ff @(posedge ref_clk) begin
        if (srst || warm_rst) begin
            step_ff <= 2'd0;
            gap_ff  <= 4'h0;
        end else if (key1_hit) begin
            step_ff <= 2'd1;
            gap_ff  <= 4'h0;
        end else if (key2_hit && step_ff == 2'd1 && gap_ff == EDA_GAP_CHK) begin
            step_ff <= 2'd2;
            gap_ff  <= 4'h0;
        end else if (unlock_we || ctrl_we || gap_ff > EDA_GAP_CHK) begin
            step_ff <= 2'd0;
            gap_ff  <= 4'h0;
        end else if (step_ff != 2'd0) begin
            gap_ff  <= gap_ff + 4'h1;
        end
    end

    // strobes: software sets, hardware clears
    always_ff @(posedge ref_clk) begin
        if (srst || warm_rst) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
        end else begin
            rd_ff <= rd_set; // one cycle read
            // gate clearing mid-write has no say here
            if (wr_go) begin
                wr_ff <= 1'b1;
            end else if (prog_end) begin
                wr_ff <= 1'b0;
            end
        end
    end

    // gate changes by software or power-up only; warm reset leaves it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gate_ff <= 1'b0;
        end else if (ctrl_we) begin
            gate_ff <= sfr_req.wdata[EDA_B_GATE];
        end
    end

    // error flag: abort by warm reset wins over a software write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            err_ff <= 1'b0;
        end else if (warm_rst && wr_ff) begin
            err_ff <= 1'b1;
        end else if (ctrl_we) begin
            err_ff <= sfr_req.wdata[EDA_B_ERR];
        end
    end

    // data and location registers
    always_ff @(posedge ref_clk) begin
        if (srst || (warm_rst && wr_ff)) begin
            data_ff <= 8'h00;
            loc_ff  <= 8'h00;
        end else begin
            // read result beats a same-cycle software write
            if (rd_ff) begin
                data_ff <= rd_byte;
            end else if (data_we) begin
                data_ff <= sfr_req.wdata;
            end
            if (loc_we) begin
                loc_ff <= sfr_req.wdata;
            end
        end
    end

    // done flag: set wins over a clearing write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            done_ff <= 1'b0;
        end else if (prog_end) begin
            done_ff <= 1'b1;
        end else if (flags_we) begin
            done_ff <= sfr_req.wdata[EDA_B_DONE];
        end
    end

    // enables and interrupt request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            done_ie_ff <= 1'b0;
            gie_ff     <= 1'b0;
            peripheral_irq_enable_ff    <= 1'b0;
            irq_req_ff <= 1'b0;
        end else begin
            if (enab_we) begin
                done_ie_ff <= sfr_req.wdata[EDA_B_DONE];
            end
            if (gic_we) begin
                gie_ff  <= sfr_req.wdata[EDA_B_GIE];
                peripheral_irq_enable_ff <= sfr_req.wdata[EDA_B_PERIPHERAL_IRQ_ENABLE];
            end
            irq_req_ff <= done_ff && done_ie_ff && gie_ff && peripheral_irq_enable_ff;
        end
    end

    // power-up timer; long count, shorten via parameter in simulation
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pwrt_ff      <= 32'h0;
            pwrt_done_ff <= 1'b0;
        end else if (!pwrt_done_ff) begin
            pwrt_ff      <= pwrt_ff + 32'h1;
            pwrt_done_ff <= (pwrt_ff == PWRT_LAST);
        end
    end

    // registered read data, busy, strap sync
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sfr_rdata_ff        <= 8'h00;
            write_busy_ff       <= 1'b0;
            cpd_s1_ff           <= 1'b1;
            cpd_s2_ff           <= 1'b1;
            programmer_blind_ff <= 1'b0;
        end else begin
            if (sfr_req.re) begin
                sfr_rdata_ff <= rd_mux;
            end
            write_busy_ff       <= (nxt_state != EDA_IDLE);
            cpd_s1_ff           <= data_protect_config;
            cpd_s2_ff           <= cpd_s1_ff;
            // strap low hides data from the programmer only
            programmer_blind_ff <= !cpd_s2_ff;
        end
    end

    // checks; the edge that releases srst still shows reset state, so they wait one more edge
    logic chk_rst_ff; // srst as seen at the last edge
    always_ff @(posedge ref_clk) begin
        chk_rst_ff <= srst;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || chk_rst_ff);
    localparam int K_GAP = 2;

    sequence s_key1;
        key1_hit && !warm_rst;
    endsequence
    // stray control writes or a warm reset between keys drop the sequence
    sequence s_unlock;
        s_key1 ##1 !unlock_we && !ctrl_we && !warm_rst ##1 key2_hit && !warm_rst
            ##1 !unlock_we && !ctrl_we && !warm_rst ##1 1'b1;
    endsequence

    property p_rd_load;
        rd_ff && !warm_rst |=> (rd_ff == $past(rd_set)) && (data_ff == $past(rd_byte));
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read byte not loaded");
    property p_data_hold;
        !rd_ff && !data_we && !warm_rst |=> $stable(data_ff);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data byte changed");
    property p_unlock_start;
        (s_unlock ##0 (ctrl_we && sfr_req.wdata[EDA_B_WR] && gate_ff && pwrt_done_ff
            && state_ff == EDA_IDLE && !warm_rst)) |=> wr_ff;
    endproperty
    a_unlock_start: assert property (p_unlock_start) else $error("unlock failed");
    property p_short_gap;
        (key1_hit ##1 key2_hit ##K_GAP ctrl_we) ##0 !wr_ff |=> !wr_ff;
    endproperty
    a_short_gap: assert property (p_short_gap) else $error("bad gap wrote");
    property p_gate_block;
        !wr_ff && !gate_ff |=> !wr_ff;
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("write without gate");
    property p_gate_hold;
        !ctrl_we |=> $stable(gate_ff);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate moved");
    property p_finish;
        prog_end |=> !wr_ff && done_ff && state_ff == EDA_IDLE;
    endproperty
    a_finish: assert property (p_finish) else $error("write end wrong");
    property p_done_sticky;
        done_ff && !flags_we |=> done_ff;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");
    property p_pwrt;
        !pwrt_done_ff |-> !wr_ff;
    endproperty
    a_pwrt: assert property (p_pwrt) else $error("write during power-up");
    property p_abort;
        warm_rst && wr_ff |=> err_ff && !wr_ff && loc_ff == 8'h00 && data_ff == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not flagged");
    property p_unlock_read;
        sfr_req.re && sfr_req.sel == EDA_SEL_UNLOCK |=> sfr_rdata_ff == 8'h00;
    endproperty
    a_unlock_read: assert property (p_unlock_read) else $error("unlock read nonzero");
endmodule : eda_eeprom_ctrl

// >>> logic/eda_pkg.sv
// constants and carrier types for the data eeprom access block
// assumes a core that reaches the block's special registers by select code
package eda_pkg;
    // special register select codes
    localparam logic [2:0] EDA_SEL_GIC    = 3'h0; // global_interrupt_control
    localparam logic [2:0] EDA_SEL_FLAGS  = 3'h1; // peripheral_interrupt_flags
    localparam logic [2:0] EDA_SEL_ENAB   = 3'h2; // peripheral_interrupt_enables
    localparam logic [2:0] EDA_SEL_DATA   = 3'h3; // eeprom_data_byte
    localparam logic [2:0] EDA_SEL_LOC    = 3'h4; // eeprom_location
    localparam logic [2:0] EDA_SEL_CTRL   = 3'h5; // eeprom_control
    localparam logic [2:0] EDA_SEL_UNLOCK = 3'h6; // eeprom_unlock_port
    // eeprom_control bit positions
    localparam int EDA_B_RD   = 0;
    localparam int EDA_B_WR   = 1;
    localparam int EDA_B_GATE = 2;
    localparam int EDA_B_ERR  = 3;
    // flag / enable / global bit positions
    localparam int EDA_B_DONE = 7; // write_done_flag, write_done_irq_enable
    localparam int EDA_B_GIE  = 7; // global_irq_enable
    localparam int EDA_B_PERIPHERAL_IRQ_ENABLE = 6; // peripheral_irq_enable
    // unlock keys and spacing in core cycles
    localparam logic [7:0] EDA_KEY1      = 8'h55;
    localparam logic [7:0] EDA_KEY2      = 8'haa;
    localparam logic [7:0] EDA_ERASED    = 8'hff;
    localparam logic [7:0] EDA_ZERO      = 8'h00;
    localparam logic [3:0] EDA_UNLOCK_GAP = 4'h2;
    localparam logic [3:0] EDA_GAP_CHK   = EDA_UNLOCK_GAP - 4'h1;
    // timing
    localparam int EDA_CLK_KHZ   = 40000;
    localparam int EDA_PWRT_MS   = 64;
    localparam int EDA_PWRT_CYC  = EDA_PWRT_MS * EDA_CLK_KHZ;
    localparam int EDA_WRITE_MS  = 5;
    localparam int EDA_WRITE_CYC = EDA_WRITE_MS * EDA_CLK_KHZ;
    // write sequencer states, gray along idle-erase-program
    typedef enum logic [1:0] {
        EDA_IDLE  = 2'b00,
        EDA_ERASE = 2'b01,
        EDA_PROG  = 2'b11
    } eda_state_t;
    // one core access to a special register
    typedef struct packed {
        logic       we;
        logic       re;
        logic [2:0] sel;
        logic [7:0] wdata;
    } eda_sfr_req_t;
endpackage : eda_pkg

// >>> sim/eda_core_model.sv
// core model: drives the special register port the way firmware would
// assumes the block samples one request at each rising edge of ref_clk
`timescale 1ns/1ps
module eda_core_model
    import eda_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic [7:0]   rdata,
    output eda_sfr_req_t      sfr_req
);
    // quiet port at time zero
    initial sfr_req = '0;

    // one request launched at an edge, held until the next call
    task automatic acc(input logic we, input logic re, input logic [2:0] sel,
                       input logic [7:0] d);
        @(posedge ref_clk);
        sfr_req <= '{we: we, re: re, sel: sel, wdata: d};
    endtask : acc

    // idle cycle; select and data churn so stale values never look valid
    task automatic idle();
        acc(1'b0, 1'b0, 3'($urandom), 8'($urandom));
    endtask : idle

    // single register write
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        acc(1'b1, 1'b0, sel, d);
    endtask : wr

    // register read; answer is registered, so sample one edge later
    task automatic rd(input logic [2:0] sel, output logic [7:0] v);
        acc(1'b0, 1'b1, sel, 8'($urandom));
        idle();
        #1 v = rdata;
    endtask : rd

    // load, unlock and strobe; gap idles between keys, 1 is the legal spacing
    task automatic start_write(input logic [7:0] a, input logic [7:0] d,
                               input logic gate, input logic [7:0] ctl,
                               input int gap, input logic [7:0] k1);
        wr(EDA_SEL_LOC, a);
        wr(EDA_SEL_DATA, d);
        wr(EDA_SEL_GIC, EDA_ZERO);
        wr(EDA_SEL_CTRL, {5'h0, gate, 2'h0});
        wr(EDA_SEL_UNLOCK, k1);
        repeat (gap) idle();
        wr(EDA_SEL_UNLOCK, ~k1);
        idle();
        wr(EDA_SEL_CTRL, ctl);
        idle();
    endtask : start_write
endmodule : eda_core_model

// >>> sim/tb.sv
// self-checking bench for the data eeprom access block
// assumes short power-up and write counts set through the parameters
`timescale 1ns/1ps
module tb;
    import eda_pkg::*;
    localparam int PWRT = 20; // shortened power-up hold
    localparam int WCYC = 8;  // shortened write time
    logic         ref_clk;
    logic         srst;
    logic         warm_rst;
    logic         strap;
    eda_sfr_req_t sfr_req;
    logic [7:0]   rdata;
    logic         irq;
    logic         busy;
    logic         blind;
    int           failures;
    int           compares;
    int           cyc;
    int           n;
    logic [7:0]   v;
    logic [7:0]   a;
    logic [7:0]   d;

    eda_eeprom_ctrl #(.DEPTH(256), .PWRT_CYC(PWRT), .WRITE_CYC(WCYC)) u_eda_eeprom_ctrl (
        .ref_clk(ref_clk), .srst(srst), .warm_rst(warm_rst), .sfr_req(sfr_req),
        .data_protect_config(strap), .sfr_rdata_ff(rdata), .irq_req_ff(irq),
        .write_busy_ff(busy), .programmer_blind_ff(blind));
    eda_core_model u_core (.ref_clk(ref_clk), .rdata(rdata), .sfr_req(sfr_req));

    // 40 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // expected control byte {err, gate, wr, rd}
    function automatic logic [7:0] ctl_exp(input logic e, input logic g, input logic w);
        return {4'h0, e, g, w, 1'b0};
    endfunction : ctl_exp

    // one comparison
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // read a register and compare
    task automatic rchk(input string what, input logic [2:0] sel, input logic [7:0] exp);
        u_core.rd(sel, v);
        check(what, v, exp);
    endtask : rchk

    // wait out a write without touching registers, bounded
    task automatic finish_write();
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask : finish_write

    task automatic give_verdict();
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        srst = 1'b1;
        warm_rst = 1'b0;
        strap = 1'b1;
        failures = 0;
        compares = 0;
        cyc = 0;
        void'($urandom(61312));
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        // every register reads zero after power-up, unlock port included
        for (int s = 0; s < 8; s++) rchk("reset value", 3'(s), EDA_ZERO);
        // second power-up restarts the timer; full sequence inside it is blocked
        @(posedge ref_clk) srst <= 1'b1;
        @(posedge ref_clk) srst <= 1'b0;
        u_core.start_write(8'h10, 8'h3c, 1'b1, 8'h06, 1, EDA_KEY1);
        #1 check("busy in hold", {7'h0, busy}, EDA_ZERO);
        repeat (PWRT) @(posedge ref_clk);
        rchk("gate kept", EDA_SEL_CTRL, ctl_exp(1'b0, 1'b1, 1'b0));
        // strobe without the gate is ignored
        u_core.start_write(8'h11, 8'h22, 1'b0, 8'h02, 1, EDA_KEY1);
        #1 check("busy no gate", {7'h0, busy}, EDA_ZERO);
        rchk("ctrl no gate", EDA_SEL_CTRL, EDA_ZERO);
        // key spacing one short, one long, and keys swapped
        for (int k = 0; k < 3; k++) begin
            u_core.start_write(8'h12, 8'h33, 1'b1, 8'h06, (k == 1) ? 2 : 0,
                               (k == 2) ? EDA_KEY2 : EDA_KEY1);
            #1 check("busy bad unlock", {7'h0, busy}, EDA_ZERO);
        end
        // random good writes, gate cleared mid-write on the first
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            @(posedge ref_clk) strap <= 1'($urandom);
            u_core.wr(EDA_SEL_ENAB, 8'h80);
            u_core.start_write(a, d, 1'b1, 8'h06, 1, EDA_KEY1);
            #1 check("busy start", {7'h0, busy}, 8'h01);
            rchk("strobe held", EDA_SEL_CTRL, ctl_exp(1'b0, 1'b1, 1'b1));
            // a single stray control write mid-write, then the port goes quiet
            if (i == 0) begin
                u_core.wr(EDA_SEL_CTRL, EDA_ZERO);
                u_core.idle();
            end
            finish_write();
            check("busy end", {7'h0, busy}, EDA_ZERO);
            rchk("ctrl end", EDA_SEL_CTRL, ctl_exp(1'b0, i != 0, 1'b0));
            rchk("done flag", EDA_SEL_FLAGS, 8'h80);
            u_core.wr(EDA_SEL_GIC, 8'hc0);
            u_core.idle();
            u_core.idle();
            #1 check("irq on", {7'h0, irq}, 8'h01);
            u_core.wr(EDA_SEL_FLAGS, EDA_ZERO);
            u_core.idle();
            u_core.idle();
            #1 check("irq off", {7'h0, irq}, EDA_ZERO);
            // read back the written byte through the read strobe
            u_core.wr(EDA_SEL_DATA, ~d);
            u_core.wr(EDA_SEL_LOC, a);
            u_core.wr(EDA_SEL_CTRL, 8'h01);
            u_core.idle();
            rchk("read back", EDA_SEL_DATA, d);
            u_core.wr(EDA_SEL_LOC, ~a);
            rchk("data held", EDA_SEL_DATA, d);
            check("blind", {7'h0, blind}, {7'h0, ~strap});
        end
        // warm reset in mid-write leaves error set and clears location and data
        u_core.start_write(8'h5a, 8'hc3, 1'b1, 8'h06, 1, EDA_KEY1);
        @(posedge ref_clk) warm_rst <= 1'b1;
        @(posedge ref_clk) warm_rst <= 1'b0;
        #1 check("busy aborted", {7'h0, busy}, EDA_ZERO);
        rchk("error flag", EDA_SEL_CTRL, ctl_exp(1'b1, 1'b1, 1'b0));
        rchk("loc cleared", EDA_SEL_LOC, EDA_ZERO);
        rchk("data cleared", EDA_SEL_DATA, EDA_ZERO);
        give_verdict();
    end
endmodule : tb
